// ---- core/afcr_bank.sv ----
// APB register bank for frequency correction, offset estimate and signal strength engines
`timescale 1ns/1ps
`include "afcr_regs.svh"

// Contract
// - Hold 8-bit fixed slicer level, default 6 dB, used only in fixed mode.
// - Offset-estimate trigger starts measurement, reads zero; done low while running.
// - Correction done low while correcting, high when finished; resets to one.
// - Auto-clear zeroes correction result before each phase, only with auto-correct on.
// - Auto-correct on: correct at every receive entry; off: only on trigger.
// - Clear bit written one in receive mode zeroes correction result; reads zero.
// - Correction trigger starts a frequency correction and always reads zero.
// - Correction result is 16-bit signed, high byte then low byte, resets zero.
// - Applied correction equals signed result times synthesizer step.
// - Offset estimate is 16-bit signed read-only, split across two bytes.
// - Strength done low while sampling, high with result; resets to one.
// - Strength trigger starts a sample and always reads zero.
// - Strength level in half-dB magnitude steps, resets to all ones.
// - Slicer type codes: 00 fixed, 01 peak, 10 average, 11 reserved.
module afcr_bank #(
  parameter int STEP_W = 16
) (
  // APB slave
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Receiver state
  input  wire logic                  rx_mode,
  // Correction engine
  output logic                       corr_start,
  input  wire logic                  corr_finish,
  input  wire logic [15:0]           corr_result,
  input  wire logic [STEP_W-1:0]     freq_step,
  output logic      [STEP_W+15:0]    corr_applied,
  // Offset estimate engine
  output logic                       offs_start,
  input  wire logic                  offs_finish,
  input  wire logic [15:0]           offs_result,
  output logic      [STEP_W+15:0]    offs_error,
  // Strength engine
  output logic                       str_start,
  input  wire logic                  str_finish,
  input  wire logic [7:0]            str_result,
  // Slicer
  output logic      [1:0]            ook_slicer_threshold_type,
  output logic      [7:0]            slicer_level,
  // Interrupt
  output logic                       irq
);

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic       wr_en;
  logic       rd_hit;
  logic [5:0] a_idx;
  logic       known;

  assign a_idx   = paddr[7:2];
  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;

  always_comb begin
    case ({2'b00, a_idx})
      `AFCR_IDX_OOK_FIX, `AFCR_IDX_CORR_CTRL, `AFCR_IDX_CORR_HIGH, `AFCR_IDX_CORR_LOW,
      `AFCR_IDX_OFFS_HIGH, `AFCR_IDX_OFFS_LOW, `AFCR_IDX_STR_CTRL, `AFCR_IDX_STR_LEVEL,
      `AFCR_IDX_SLICER_TYPE, `AFCR_IDX_IRQ_STATUS, `AFCR_IDX_IRQ_MASK: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // Unmapped or misaligned addresses answer with an error
  assign rd_hit  = known && (paddr[1:0] == 2'b00);
  assign pslverr = psel && penable && !rd_hit;

  function automatic logic hit(input logic [7:0] idx);
    hit = wr_en && rd_hit && ({2'b00, a_idx} == idx);
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers for the receive-state input
  // --------------------------------------------------------------------------
  logic rx_s1_q;
  logic rx_s2_q;
  logic rx_prev_q;
  logic rx_enter;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_q   <= 1'b0;
      rx_s2_q   <= 1'b0;
      rx_prev_q <= 1'b0;
    end else begin
      rx_s1_q   <= rx_mode;
      rx_s2_q   <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
    end
  end

  assign rx_enter = rx_s2_q && !rx_prev_q;

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  logic [7:0] ook_fixed_level_q;
  logic [7:0] ook_fixed_level_d;
  logic [1:0] slicer_type_q;
  logic [1:0] slicer_type_d;
  logic [7:0] slicer_level_q;
  logic [7:0] slicer_level_d;
  logic       auto_clear_correction_q;
  logic       auto_correct_on_rx_q;

  always_comb begin
    ook_fixed_level_d = ook_fixed_level_q;
    slicer_type_d     = slicer_type_q;
    if (hit(`AFCR_IDX_OOK_FIX)) begin
      ook_fixed_level_d = pwdata[7:0];
    end
    if (hit(`AFCR_IDX_SLICER_TYPE)) begin
      slicer_type_d = pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ook_fixed_level_q <= `AFCR_RST_OOK_FIX;
      slicer_type_q     <= `AFCR_RST_SLICER_TYPE;
    end else begin
      ook_fixed_level_q <= ook_fixed_level_d;
      slicer_type_q     <= slicer_type_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_clear_correction_q <= 1'b0;
      auto_correct_on_rx_q    <= 1'b0;
    end else if (hit(`AFCR_IDX_CORR_CTRL)) begin
      auto_clear_correction_q <= pwdata[`AFCR_BIT_AUTO_CLEAR];
      auto_correct_on_rx_q    <= pwdata[`AFCR_BIT_AUTO_RX];
    end
  end

  assign ook_slicer_threshold_type = slicer_type_q;

  // Fixed level reaches the slicer only in fixed mode; other modes get zero.
  // Built from the next values so level and type change on the same edge.
  assign slicer_level_d = (slicer_type_d == afcr_pkg::AFCR_SLICE_FIXED) ?
                          ook_fixed_level_d : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Reset type is peak, so no fixed level is applied
      slicer_level_q <= 8'h00;
    end else begin
      slicer_level_q <= slicer_level_d;
    end
  end

  assign slicer_level = slicer_level_q;

  // --------------------------------------------------------------------------
  // Triggers (self-clearing, never stored)
  // --------------------------------------------------------------------------
  logic corr_trig_wr;
  logic corr_clear_wr;
  logic offs_trig_wr;
  logic str_trig_wr;

  assign corr_trig_wr  = hit(`AFCR_IDX_CORR_CTRL) && pwdata[`AFCR_BIT_CORR_TRIG];
  assign corr_clear_wr = hit(`AFCR_IDX_CORR_CTRL) && pwdata[`AFCR_BIT_CORR_CLEAR];
  assign offs_trig_wr  = hit(`AFCR_IDX_CORR_CTRL) && pwdata[`AFCR_BIT_OFFS_TRIG];
  assign str_trig_wr   = hit(`AFCR_IDX_STR_CTRL) && pwdata[`AFCR_BIT_STR_TRIG];

  // Auto mode starts on receive entry; manual trigger stays valid in either mode
  assign corr_start = corr_trig_wr || (auto_correct_on_rx_q && rx_enter);
  assign offs_start = offs_trig_wr;
  assign str_start  = str_trig_wr;

  // --------------------------------------------------------------------------
  // Engine busy states
  // --------------------------------------------------------------------------
  afcr_pkg::afcr_eng_e corr_st_q;
  afcr_pkg::afcr_eng_e offs_st_q;
  afcr_pkg::afcr_eng_e str_st_q;

  // Finish seen in the same cycle as a new start keeps the engine busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      corr_st_q <= afcr_pkg::AFCR_ENG_IDLE;
    end else begin
      case (corr_st_q)
        afcr_pkg::AFCR_ENG_IDLE: if (corr_start) corr_st_q <= afcr_pkg::AFCR_ENG_BUSY;
        afcr_pkg::AFCR_ENG_BUSY: if (corr_finish && !corr_start) begin
          corr_st_q <= afcr_pkg::AFCR_ENG_IDLE;
        end
        default: corr_st_q <= afcr_pkg::AFCR_ENG_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offs_st_q <= afcr_pkg::AFCR_ENG_IDLE;
    end else begin
      case (offs_st_q)
        afcr_pkg::AFCR_ENG_IDLE: if (offs_start) offs_st_q <= afcr_pkg::AFCR_ENG_BUSY;
        afcr_pkg::AFCR_ENG_BUSY: if (offs_finish && !offs_start) begin
          offs_st_q <= afcr_pkg::AFCR_ENG_IDLE;
        end
        default: offs_st_q <= afcr_pkg::AFCR_ENG_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      str_st_q <= afcr_pkg::AFCR_ENG_IDLE;
    end else begin
      case (str_st_q)
        afcr_pkg::AFCR_ENG_IDLE: if (str_start) str_st_q <= afcr_pkg::AFCR_ENG_BUSY;
        afcr_pkg::AFCR_ENG_BUSY: if (str_finish && !str_start) begin
          str_st_q <= afcr_pkg::AFCR_ENG_IDLE;
        end
        default: str_st_q <= afcr_pkg::AFCR_ENG_IDLE;
      endcase
    end
  end

  logic freq_correction_done;
  logic offset_estimate_done;
  logic strength_sample_done;
  logic corr_end;
  logic offs_end;
  logic str_end;

  assign freq_correction_done = (corr_st_q == afcr_pkg::AFCR_ENG_IDLE);
  assign offset_estimate_done = (offs_st_q == afcr_pkg::AFCR_ENG_IDLE);
  assign strength_sample_done = (str_st_q == afcr_pkg::AFCR_ENG_IDLE);
  assign corr_end = (corr_st_q == afcr_pkg::AFCR_ENG_BUSY) && corr_finish && !corr_start;
  assign offs_end = (offs_st_q == afcr_pkg::AFCR_ENG_BUSY) && offs_finish && !offs_start;
  assign str_end  = (str_st_q == afcr_pkg::AFCR_ENG_BUSY) && str_finish && !str_start;

  // --------------------------------------------------------------------------
  // Result registers
  // --------------------------------------------------------------------------
  logic [15:0] correction_value_q;
  logic [15:0] offset_estimate_value_q;
  logic [7:0]  strength_level_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      correction_value_q <= `AFCR_RST_CORR_VALUE;
    end else if (corr_end) begin
      correction_value_q <= corr_result;
    end else if (corr_start && auto_correct_on_rx_q && auto_clear_correction_q) begin
      correction_value_q <= `AFCR_RST_CORR_VALUE;
    end else if (corr_clear_wr && rx_s2_q) begin
      correction_value_q <= `AFCR_RST_CORR_VALUE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_estimate_value_q <= `AFCR_RST_OFFS_VALUE;
    end else if (offs_end) begin
      offset_estimate_value_q <= offs_result;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strength_level_q <= `AFCR_RST_STR_LEVEL;
    end else if (str_end) begin
      strength_level_q <= str_result;
    end
  end

  // Signed products by the synthesizer step; step is unsigned.
  // Operands are widened first so the product keeps all its bits.
  logic signed [STEP_W+15:0] corr_wide;
  logic signed [STEP_W+15:0] offs_wide;
  logic signed [STEP_W+15:0] step_wide;
  logic        [STEP_W+15:0] corr_applied_q;
  logic        [STEP_W+15:0] offs_error_q;

  assign corr_wide = (STEP_W+16)'($signed(correction_value_q));
  assign offs_wide = (STEP_W+16)'($signed(offset_estimate_value_q));
  assign step_wide = (STEP_W+16)'({1'b0, freq_step});

  // Registered outputs lag the result registers and the step by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      corr_applied_q <= '0;
      offs_error_q   <= '0;
    end else begin
      corr_applied_q <= corr_wide * step_wide;
      offs_error_q   <= offs_wide * step_wide;
    end
  end

  assign corr_applied = corr_applied_q;
  assign offs_error   = offs_error_q;

  // --------------------------------------------------------------------------
  // Interrupts: sticky completion flags, write one to clear, set wins
  // --------------------------------------------------------------------------
  logic [2:0] irq_status_q;
  logic [2:0] irq_mask_q;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;

  assign irq_set = {str_end, offs_end, corr_end};
  assign irq_clr = hit(`AFCR_IDX_IRQ_STATUS) ? pwdata[2:0] : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= 3'h0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= 3'h0;
    end else if (hit(`AFCR_IDX_IRQ_MASK)) begin
      irq_mask_q <= pwdata[2:0];
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // --------------------------------------------------------------------------
  // Read mux: triggers and clear read zero, unused bits zero
  // --------------------------------------------------------------------------
  logic [31:0] rd_word;
  logic [31:0] prdata_q;

  always_comb begin
    rd_word = 32'h0;
    case ({2'b00, a_idx})
      `AFCR_IDX_OOK_FIX:     rd_word[7:0] = ook_fixed_level_q;
      `AFCR_IDX_CORR_CTRL: begin
        rd_word[`AFCR_BIT_OFFS_DONE]  = offset_estimate_done;
        rd_word[`AFCR_BIT_CORR_DONE]  = freq_correction_done;
        rd_word[`AFCR_BIT_AUTO_CLEAR] = auto_clear_correction_q;
        rd_word[`AFCR_BIT_AUTO_RX]    = auto_correct_on_rx_q;
      end
      `AFCR_IDX_CORR_HIGH:   rd_word[7:0] = correction_value_q[15:8];
      `AFCR_IDX_CORR_LOW:    rd_word[7:0] = correction_value_q[7:0];
      `AFCR_IDX_OFFS_HIGH:   rd_word[7:0] = offset_estimate_value_q[15:8];
      `AFCR_IDX_OFFS_LOW:    rd_word[7:0] = offset_estimate_value_q[7:0];
      `AFCR_IDX_STR_CTRL:    rd_word[`AFCR_BIT_STR_DONE] = strength_sample_done;
      `AFCR_IDX_STR_LEVEL:   rd_word[7:0] = strength_level_q;
      `AFCR_IDX_SLICER_TYPE: rd_word[1:0] = slicer_type_q;
      `AFCR_IDX_IRQ_STATUS:  rd_word[2:0] = irq_status_q;
      `AFCR_IDX_IRQ_MASK:    rd_word[2:0] = irq_mask_q;
      default:               rd_word = 32'h0;
    endcase
  end

  // Read word is taken at the end of the setup cycle and stands from a flop
  // through the access cycle: no wait state, but it shows the state of the
  // cycle before the access edge. Zero outside a read access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (psel && !penable && !pwrite && rd_hit) begin
      prdata_q <= rd_word;
    end else begin
      prdata_q <= 32'h0;
    end
  end

  assign prdata = prdata_q;

endmodule // afcr_bank

// ---- core/afcr_pkg.sv ----
// Types shared by the measurement register bank
package afcr_pkg;
  typedef enum logic [1:0] {
    AFCR_SLICE_FIXED   = 2'b00,
    AFCR_SLICE_PEAK    = 2'b01,
    AFCR_SLICE_AVERAGE = 2'b10,
    AFCR_SLICE_RSVD    = 2'b11
  } afcr_slice_e;

  typedef enum logic [0:0] {
    AFCR_ENG_IDLE = 1'b0,
    AFCR_ENG_BUSY = 1'b1
  } afcr_eng_e;
endpackage

// ---- core/afcr_regs.svh ----
// Register offsets, field positions and reset values of the measurement register bank
`ifndef AFCR_REGS_SVH
`define AFCR_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is index times four)
// ----------------------------------------------------------------------------
`define AFCR_IDX_OOK_FIX        8'h1d
`define AFCR_IDX_CORR_CTRL      8'h1e
`define AFCR_IDX_CORR_HIGH      8'h1f
`define AFCR_IDX_CORR_LOW       8'h20
`define AFCR_IDX_OFFS_HIGH      8'h21
`define AFCR_IDX_OFFS_LOW       8'h22
`define AFCR_IDX_STR_CTRL       8'h23
`define AFCR_IDX_STR_LEVEL      8'h24
`define AFCR_IDX_SLICER_TYPE    8'h30
`define AFCR_IDX_IRQ_STATUS     8'h31
`define AFCR_IDX_IRQ_MASK       8'h32

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define AFCR_BIT_OFFS_DONE      6
`define AFCR_BIT_OFFS_TRIG      5
`define AFCR_BIT_CORR_DONE      4
`define AFCR_BIT_AUTO_CLEAR     3
`define AFCR_BIT_AUTO_RX        2
`define AFCR_BIT_CORR_CLEAR     1
`define AFCR_BIT_CORR_TRIG      0
`define AFCR_BIT_STR_DONE       1
`define AFCR_BIT_STR_TRIG       0
`define AFCR_IRQ_CORR           0
`define AFCR_IRQ_OFFS           1
`define AFCR_IRQ_STR            2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define AFCR_RST_OOK_FIX        8'h06
`define AFCR_RST_SLICER_TYPE    2'h1
`define AFCR_RST_CORR_VALUE     16'h0000
`define AFCR_RST_OFFS_VALUE     16'h0000
`define AFCR_RST_STR_LEVEL      8'hff

`endif

// ---- tb/afcr_bank_properties.sv ----
// Port-level assertions for the measurement register bank
`timescale 1ns/1ps
module afcr_bank_properties (
  // APB
  input wire logic        pclk, presetn, psel, penable, pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata,
  // Engines and slicer
  input wire logic        corr_start, offs_start, str_start, str_finish,
  input wire logic [1:0]  ook_slicer_threshold_type,
  input wire logic [7:0]  slicer_level
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic rd;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  // ----------------------------------------------------------------
  // Triggers and self-clearing bits
  // ----------------------------------------------------------------
  a_corr_trig: assert property (wr && paddr == 8'h78 && pwdata[0] |-> corr_start)
    else $error("correction trigger write gave no start");
  a_offs_trig: assert property (wr && paddr == 8'h78 && pwdata[5] |-> offs_start)
    else $error("offset trigger write gave no start");
  a_offs_cause: assert property (offs_start |-> wr && paddr == 8'h78 && pwdata[5])
    else $error("offset start without trigger write");
  a_str_trig: assert property (wr && paddr == 8'h8c && pwdata[0] |-> str_start)
    else $error("strength trigger write gave no start");
  a_str_cause: assert property (str_start |-> wr && paddr == 8'h8c && pwdata[0])
    else $error("strength start without trigger write");
  a_ctrl_wo_bits: assert property (rd && paddr == 8'h78 |->
    prdata[7] == 1'b0 && prdata[5] == 1'b0 && prdata[1:0] == 2'b00)
    else $error("control write-only or unused bit read nonzero");
  a_str_ctrl_bits: assert property (rd && paddr == 8'h8c |->
    prdata[7:2] == 6'h00 && prdata[0] == 1'b0)
    else $error("strength control unused or trigger bit read nonzero");
  // Done must read low in an access three cycles after a start when no finish came in between
  a_str_busy: assert property ((str_start && !str_finish) ##1 !str_finish [*2]
    ##1 (rd && paddr == 8'h8c) |-> prdata[1] == 1'b0)
    else $error("strength done high while sampling");
  // ----------------------------------------------------------------
  // Slicer level
  // ----------------------------------------------------------------
  a_slicer_gate: assert property (
    ook_slicer_threshold_type != 2'b00 |-> slicer_level == 8'h00)
    else $error("fixed level applied outside fixed mode");
  a_slicer_fixed: assert property (
    ook_slicer_threshold_type == 2'b00 && rd && paddr == 8'h74 |-> prdata[7:0] == slicer_level)
    else $error("fixed level not applied in fixed mode");
  cover property (corr_start);
  cover property (str_start ##3 (rd && paddr == 8'h8c));
  cover property (ook_slicer_threshold_type == 2'b00 && slicer_level != 8'h00);
endmodule // afcr_bank_properties

bind afcr_bank afcr_bank_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .corr_start, .offs_start, .str_start, .str_finish,
  .ook_slicer_threshold_type, .slicer_level);

// ---- tb/afcr_bank_test.sv ----
// Self-checking bench for the measurement register bank
`timescale 1ns/1ps
module afcr_bank_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_mode, irq;
  logic        corr_start, corr_finish, offs_start, offs_finish, str_start, str_finish;
  logic [7:0]  paddr, str_result, slicer_level, lv;
  logic [31:0] pwdata, prdata, corr_applied, offs_error, rd;
  logic [15:0] corr_result, offs_result, freq_step, cv, ov;
  logic [1:0]  ook_slicer_threshold_type;
  logic        err;
  int          errors = 0;
  int          checked = 0;
  int          cyc = 0;

  afcr_bank dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_mode, .corr_start, .corr_finish, .corr_result, .freq_step,
    .corr_applied, .offs_start, .offs_finish, .offs_result, .offs_error, .str_start,
    .str_finish, .str_result, .ook_slicer_threshold_type, .slicer_level, .irq);

  // ----------------------------------------------------------------
  // Clock, timeout and report
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Whole run is well under a thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors = errors + 1;
      results();
    end
  end

  task results();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus, engine and compare helpers
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Idle cycle after each transfer keeps psel from being driven twice in one step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  task fin(input int k);
    case (k)
      0: corr_finish <= 1'b1;
      1: offs_finish <= 1'b1;
      default: str_finish <= 1'b1;
    endcase
    @(posedge pclk);
    {corr_finish, offs_finish, str_finish} <= 3'b000;
    @(posedge pclk);
  endtask

  task ev(input int k);
    chk(irq, 32'h1);
    rdc(8'hc4, 32'h7, 32'h1 << k);
    apb(1'b1, 8'hc4, 32'h1 << k);
    chk(irq, 32'h0);
  endtask

  function automatic logic [31:0] prod(input logic [15:0] v, input logic [15:0] s);
    return 32'(longint'($signed(v)) * longint'(s));
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rx_mode} = '0;
    {corr_finish, offs_finish, str_finish, corr_result, offs_result, str_result} = '0;
    freq_step = 16'h0;
    presetn = 1'b0;
    void'($urandom(32'hbda3e668));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(8'h74, 32'hff, 32'h06);
    rdc(8'h7c, 32'hff, 32'h0);
    rdc(8'h80, 32'hff, 32'h0);
    rdc(8'h90, 32'hff, 32'hff);
    rdc(8'h78, 32'hbf, 32'h10);
    rdc(8'h8c, 32'hff, 32'h02);
    rdc(8'hc0, 32'h3, 32'h1);
    apb(1'b1, 8'h90, 32'h0);
    rdc(8'h90, 32'hff, 32'hff);
    apb(1'b1, 8'hfd, 32'h0);
    chk(err, 32'h1);
    chk(pready, 32'h1);
    for (int t = 2; t >= 0; t--) begin
      lv = 8'($urandom);
      apb(1'b1, 8'h74, {24'h0, lv});
      apb(1'b1, 8'hc0, t);
      chk(slicer_level, t == 0 ? lv : 8'h0);
      chk(ook_slicer_threshold_type, t);
      rdc(8'hc0, 32'h3, t);
    end
    rdc(8'h74, 32'hff, lv);
    apb(1'b1, 8'hc8, 32'h7);
    // Manual correction with a negative result
    cv = 16'($urandom) | 16'h8001;
    corr_result <= cv;
    freq_step <= 16'($urandom);
    apb(1'b1, 8'h78, 32'h1);
    rdc(8'h78, 32'h10, 32'h0);
    fin(0);
    rdc(8'h78, 32'h10, 32'h10);
    rdc(8'h7c, 32'hff, cv[15:8]);
    rdc(8'h80, 32'hff, cv[7:0]);
    chk(corr_applied, prod(cv, freq_step));
    ev(0);
    // Offset estimate
    ov = 16'($urandom);
    offs_result <= ov;
    apb(1'b1, 8'h78, 32'h20);
    rdc(8'h78, 32'h40, 32'h0);
    fin(1);
    rdc(8'h78, 32'h40, 32'h40);
    rdc(8'h84, 32'hff, ov[15:8]);
    rdc(8'h88, 32'hff, ov[7:0]);
    chk(offs_error, prod(ov, freq_step));
    ev(1);
    // Strength sample with its interrupt masked at first
    apb(1'b1, 8'hc8, 32'h3);
    lv = 8'($urandom);
    str_result <= lv;
    apb(1'b1, 8'h8c, 32'hff);
    rdc(8'h8c, 32'hff, 32'h0);
    fin(2);
    rdc(8'h8c, 32'hff, 32'h2);
    rdc(8'h90, 32'hff, lv);
    chk(irq, 32'h0);
    apb(1'b1, 8'hc8, 32'h7);
    ev(2);
    // Receive entry with auto correct and auto clear
    apb(1'b1, 8'h78, 32'h0c);
    rx_mode <= 1'b1;
    for (int i = 0; i < 10 && corr_start !== 1'b1; i++) @(negedge pclk);
    chk(corr_start, 32'h1);
    @(posedge pclk);
    rdc(8'h7c, 32'hff, 32'h0);
    rdc(8'h78, 32'h10, 32'h0);
    cv = 16'($urandom) | 16'h0101;
    corr_result <= cv;
    fin(0);
    ev(0);
    // Auto clear alone leaves the result in place
    apb(1'b1, 8'h78, 32'h08);
    apb(1'b1, 8'h78, 32'h09);
    rdc(8'h80, 32'hff, cv[7:0]);
    fin(0);
    ev(0);
    // Clear only acts in receive mode
    rx_mode <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b1, 8'h78, 32'h2);
    rdc(8'h80, 32'hff, cv[7:0]);
    rx_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    rdc(8'h78, 32'h10, 32'h10);
    apb(1'b1, 8'h78, 32'h2);
    rdc(8'h7c, 32'hff, 32'h0);
    rdc(8'h80, 32'hff, 32'h0);
    chk(corr_applied, 32'h0);
    results();
  end
endmodule // afcr_bank_test
